// ### logic/move_branch_cfg.svh
// constants: opcodes, field positions, reset values and register offsets
`ifndef MOVE_BRANCH_CFG_SVH
`define MOVE_BRANCH_CFG_SVH
// ---------------------------------------------------------------
// instruction patterns
// ---------------------------------------------------------------
`define OP_NOP       12'b0000_0000_0000
`define OP_OPTION    12'b0000_0000_0010
`define OP_PORT      12'b0000_0000_01??
`define OP_PORT_LO   3'h5
`define OP_RET       12'b0000_0000_1100
`define OP_RET_PAGE  12'b0000_0000_1101
`define OP_RET_INT   12'b0000_0000_1110
`define OP_RET_INT_ADD 12'b0000_0000_1111
`define OP_PAGE      12'b0000_0001_0???
`define OP_MODE_RD   12'b0000_0100_0010
`define OP_MODE_WR   12'b0000_0100_0011
`define OP_MODE_LIT  12'b0000_0101_????
`define OP_MOV_FW    12'b0000_001?_????
`define OP_SUB_W     12'b0000_100?_????
`define OP_DEC_W     12'b0000_110?_????
`define OP_MOV_WF    12'b0010_000?_????
`define OP_TEST      12'b0010_001?_????
`define OP_NOT_W     12'b0010_010?_????
`define OP_INC_W     12'b0010_100?_????
`define OP_DECSZ_W   12'b0010_110?_????
`define OP_RR_W      12'b0011_000?_????
`define OP_RL_W      12'b0011_010?_????
`define OP_SWAP_W    12'b0011_100?_????
`define OP_INCSZ_W   12'b0011_110?_????
`define OP_RET_LIT   12'b1000_????_????
`define OP_CALL      12'b1001_????_????
`define OP_JMP       12'b101?_????_????
`define OP_LIT_W     12'b1100_????_????
// ---------------------------------------------------------------
// status bits, file addresses, reset values, timing
// ---------------------------------------------------------------
`define ST_C         0
`define ST_DIGIT     1
`define ST_Z         2
`define ST_POWERDOWN 3
`define ST_TIMEOUT   4
`define ADDR_COUNTER 5'h01
`define ADDR_STATUS  5'h03
`define ADDR_POINTER 5'h04
`define STATUS_RST   8'h18
`define OPTION_RST   8'hff
`define MODE_RST     4'hf
`define MODE_WKPND   4'h9
`define MODE_CMP     4'h8
`define PORT_B_SEL   3'h6
`define BRANCH_EXTRA 2'h2
`define SKIP_EXTRA   2'h1
`define STACK_DEPTH  8
// ---------------------------------------------------------------
// register bus map
// ---------------------------------------------------------------
`define REG_CTRL     4'h0
`define REG_STATE    4'h4
`define REG_OPTION   4'h8
`define CTRL_FUSE    0
`define CTRL_RUN     1
`define CTRL_RST     2'h2
`define RESP_OKAY    2'h0
`define RESP_DECERR  2'h3
`endif

// ### logic/move_branch_pkg.sv
// types shared by the decoder and its helpers
package move_branch_pkg;
   typedef enum logic [2:0] {
      ALU_PASS = 3'h0, ALU_SUB = 3'h1, ALU_INC = 3'h2, ALU_DEC = 3'h3,
      ALU_NOT = 3'h4, ALU_RL = 3'h5, ALU_RR = 3'h6, ALU_SWAP = 3'h7
   } alu_e;
   typedef struct packed {
      logic [7:0] res;
      logic c;
      logic digit;
      logic z;
   } alu_out_s;
   typedef struct packed {
      logic [7:0] w;
      logic [7:0] status;
      logic [7:0] pointer;
      logic [10:0] pc;
   } ctx_s;
   typedef struct packed {
      ctx_s live;
      ctx_s shadow;
      logic [7:0] counter;
      logic [3:0] mode;
      logic [7:0] option;
      logic [1:0] stall;
      logic [7:0][7:0] port;
      logic [31:0][7:0] file;
      logic [1:0] ctrl;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } core_s;
endpackage

// ### logic/move_branch_alu.sv
// combinational data path for the move, rotate and arithmetic moves
`timescale 1ns/100ps
module move_branch_alu (
   input wire logic [7:0] a_i,                  // file operand
   input wire logic [7:0] b_i,                  // accumulator
   input wire logic c_i,                        // carry in
   input wire logic fuse_i,                     // carry chain fuse, 0 = chain
   input move_branch_pkg::alu_e op_i,           // operation
   output move_branch_pkg::alu_out_s out_o      // result and flags
);
   logic [8:0] diff;
   logic [4:0] ndiff;
   logic bin;
   // ---------------------------------------------------------------
   // operation select
   // ---------------------------------------------------------------
   always_comb begin
      bin = fuse_i ? 1'b0 : ~c_i; // borrow only with chain enabled
      diff = {1'b0, a_i} - {1'b0, b_i} - {8'h00, bin};
      ndiff = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, bin};
      out_o.c = c_i;
      out_o.digit = 1'b0;
      unique case (op_i)
         move_branch_pkg::ALU_SUB: begin
            out_o.res = diff[7:0];
            out_o.c = ~diff[8]; // carry means no borrow
            out_o.digit = ~ndiff[4];
         end
         move_branch_pkg::ALU_INC: out_o.res = a_i + 8'h01;
         move_branch_pkg::ALU_DEC: out_o.res = a_i - 8'h01;
         move_branch_pkg::ALU_NOT: out_o.res = ~a_i;
         move_branch_pkg::ALU_RL: begin
            out_o.res = {a_i[6:0], c_i};
            out_o.c = a_i[7];
         end
         move_branch_pkg::ALU_RR: begin
            out_o.res = {c_i, a_i[7:1]};
            out_o.c = a_i[0];
         end
         move_branch_pkg::ALU_SWAP: out_o.res = {a_i[3:0], a_i[7:4]};
         move_branch_pkg::ALU_PASS: out_o.res = a_i;
      endcase
      out_o.z = (out_o.res == 8'h00);
   end
endmodule // move_branch_alu

// ### logic/move_branch_stack.sv
// hardware return stack, top entry visible combinationally
`timescale 1ns/100ps
`include "move_branch_cfg.svh"
module move_branch_stack #(
   parameter int DEPTH = `STACK_DEPTH
) (
   input wire logic CLOCK_I,                    // system clock
   input wire logic SYS_RST_I,                  // synchronous reset
   input wire logic push_i,                     // push pulse
   input wire logic pop_i,                      // pop pulse
   input wire logic [10:0] data_i,              // return address
   output logic [10:0] top_o                    // current top
);
   typedef struct packed {
      logic [DEPTH-1:0][10:0] ent;
   } stack_s;
   stack_s st_reg;
   stack_s st_next;
   // shift register: overflow drops the oldest, underflow repeats it
   always_comb begin
      st_next = st_reg;
      if (push_i) begin
         st_next.ent = {st_reg.ent[DEPTH-2:0], data_i};
      end else if (pop_i) begin
         st_next.ent = {st_reg.ent[DEPTH-1], st_reg.ent[DEPTH-1:1]};
      end
   end
   always_ff @(posedge CLOCK_I) begin
      if (SYS_RST_I) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign top_o = st_reg.ent[0];
endmodule // move_branch_stack

// ### logic/move_and_branch_decoder.sv
// move and program-control instruction decoder with register bus
// Operation
// - move accumulator to file, flags kept
// - move file to accumulator, update zero
// - file minus accumulator, fuse-gated borrow, flags
// - literal into accumulator, flags kept
// - complement of file into accumulator, zero
// - file minus one into accumulator, zero
// - file plus one into accumulator, zero
// - rotate left through carry into accumulator
// - rotate right through carry into accumulator
// - nibble swap into accumulator, flags kept
// - mode into accumulator, upper nibble zero
// - inc/dec move, skip on zero result
// - accumulator or literal into mode register
// - port control write, swap for B only in mode 8 or 9
// - accumulator into option register
// - test file register for zero
// - call pushes return, three cycles
// - jump loads nine bits plus page
// - return pops in three; nop one cycle
// - cross-page return also sets page bits
// - interrupt returns restore shadows; add variant
// - literal return loads accumulator and pops
// - page bits loaded by page instruction
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "move_branch_cfg.svh"
module move_and_branch_decoder (
   input wire logic CLOCK_I,                    // 100 MHz clock
   input wire logic SYS_RST_I,                  // synchronous reset
   input wire logic [11:0] INSTR_I,             // instruction word
   input wire logic INSTR_VALID_I,              // word valid
   output logic INSTR_READY_O,                  // word accepted
   output logic [10:0] FETCH_ADDR_O,            // program counter
   input wire logic SHADOW_SAVE_I,              // capture shadow context
   output logic [7:0] W_O,                      // accumulator
   output logic [7:0] STATUS_O,                 // status register
   input wire logic [3:0] S_AXI_AWADDR,         // write address
   input wire logic S_AXI_AWVALID,              // write address valid
   output logic S_AXI_AWREADY,                  // write address ready
   input wire logic [31:0] S_AXI_WDATA,         // write data
   input wire logic [3:0] S_AXI_WSTRB,          // write strobes
   input wire logic S_AXI_WVALID,               // write data valid
   output logic S_AXI_WREADY,                   // write data ready
   output logic [1:0] S_AXI_BRESP,              // write response
   output logic S_AXI_BVALID,                   // write response valid
   input wire logic S_AXI_BREADY,               // write response ready
   input wire logic [3:0] S_AXI_ARADDR,         // read address
   input wire logic S_AXI_ARVALID,              // read address valid
   output logic S_AXI_ARREADY,                  // read address ready
   output logic [31:0] S_AXI_RDATA,             // read data
   output logic [1:0] S_AXI_RRESP,              // read response
   output logic S_AXI_RVALID,                   // read response valid
   input wire logic S_AXI_RREADY                // read response ready
);
   move_branch_pkg::core_s r_reg;
   move_branch_pkg::core_s r_next;
   move_branch_pkg::alu_e alu_sel;
   move_branch_pkg::alu_out_s alu;
   logic take;
   logic [4:0] faddr;
   logic [7:0] file_register_operand;
   logic [10:0] stack_top;
   logic push;
   logic pop;
   logic wr_go;
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // special file addresses map onto live state, others to the array
   function automatic logic [7:0] file_rd(move_branch_pkg::core_s s, logic [4:0] a);
      unique case (a)
         `ADDR_COUNTER: file_rd = s.counter;
         `ADDR_STATUS: file_rd = s.live.status;
         `ADDR_POINTER: file_rd = s.live.pointer;
         default: file_rd = s.file[a];
      endcase
   endfunction
   // status with a new zero bit
   function automatic logic [7:0] with_z(logic [7:0] st, logic z);
      with_z = st;
      with_z[`ST_Z] = z;
   endfunction
   // ---------------------------------------------------------------
   // fetch handshake and operand
   // ---------------------------------------------------------------
   // fetch held while a branch or skip completes
   assign INSTR_READY_O = r_reg.ctrl[`CTRL_RUN] && (r_reg.stall == 2'h0);
   assign take = INSTR_VALID_I && INSTR_READY_O;
   assign faddr = INSTR_I[4:0];
   assign file_register_operand = file_rd(r_reg, faddr);
   // alu selection straight from the word
   always_comb begin
      casez (INSTR_I)
         `OP_SUB_W: alu_sel = move_branch_pkg::ALU_SUB;
         `OP_DEC_W, `OP_DECSZ_W: alu_sel = move_branch_pkg::ALU_DEC;
         `OP_INC_W, `OP_INCSZ_W: alu_sel = move_branch_pkg::ALU_INC;
         `OP_NOT_W: alu_sel = move_branch_pkg::ALU_NOT;
         `OP_RL_W: alu_sel = move_branch_pkg::ALU_RL;
         `OP_RR_W: alu_sel = move_branch_pkg::ALU_RR;
         `OP_SWAP_W: alu_sel = move_branch_pkg::ALU_SWAP;
         default: alu_sel = move_branch_pkg::ALU_PASS;
      endcase
   end
   move_branch_alu u_alu (
      .a_i(file_register_operand),
      .b_i(r_reg.live.w),
      .c_i(r_reg.live.status[`ST_C]),
      .fuse_i(r_reg.ctrl[`CTRL_FUSE]),
      .op_i(alu_sel),
      .out_o(alu)
   );
   move_branch_stack u_stack (
      .CLOCK_I(CLOCK_I),
      .SYS_RST_I(SYS_RST_I),
      .push_i(push),
      .pop_i(pop),
      .data_i(11'(r_reg.live.pc + 11'h001)),
      .top_o(stack_top)
   );
   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      r_next = r_reg;
      push = 1'b0;
      pop = 1'b0;
      r_next.counter = r_reg.counter + 8'h01; // free running
      if (r_reg.stall != 2'h0) begin
         r_next.stall = r_reg.stall - 2'h1;
      end
      if (SHADOW_SAVE_I) begin
         r_next.shadow = r_reg.live;
      end
      if (take) begin
         r_next.live.pc = r_reg.live.pc + 11'h001;
         casez (INSTR_I)
            `OP_NOP: ;
            `OP_OPTION: r_next.option = r_reg.live.w;
            `OP_PORT: begin
               if (INSTR_I[2:0] < `OP_PORT_LO) begin
                  // low selectors have no port: no operation
               end else if (INSTR_I[2:0] == `PORT_B_SEL &&
                            (r_reg.mode == `MODE_WKPND || r_reg.mode == `MODE_CMP)) begin
                  r_next.port[INSTR_I[2:0]] = r_reg.live.w;
                  r_next.live.w = r_reg.port[INSTR_I[2:0]];
               end else begin
                  r_next.port[INSTR_I[2:0]] = r_reg.live.w;
               end
            end
            `OP_RET: begin
               r_next.live.pc = stack_top;
               pop = 1'b1;
               r_next.stall = `BRANCH_EXTRA;
            end
            `OP_RET_PAGE: begin
               r_next.live.pc = stack_top;
               r_next.live.status[6:5] = stack_top[10:9];
               pop = 1'b1;
               r_next.stall = `BRANCH_EXTRA;
            end
            `OP_RET_INT, `OP_RET_INT_ADD: begin
               r_next.live = r_reg.shadow;
               r_next.live.status[`ST_TIMEOUT] = r_reg.live.status[`ST_TIMEOUT];
               r_next.live.status[`ST_POWERDOWN] = r_reg.live.status[`ST_POWERDOWN];
               if (INSTR_I[0]) begin
                  r_next.counter = r_reg.counter + r_reg.shadow.w;
               end
               r_next.stall = `BRANCH_EXTRA;
            end
            `OP_PAGE: r_next.live.status[7:5] = INSTR_I[2:0];
            `OP_MODE_RD: r_next.live.w = {4'h0, r_reg.mode};
            `OP_MODE_WR: r_next.mode = r_reg.live.w[3:0];
            `OP_MODE_LIT: r_next.mode = INSTR_I[3:0];
            `OP_MOV_FW, `OP_TEST: begin
               // the file write below carries the value
            end
            `OP_SUB_W: begin
               r_next.live.w = alu.res;
               r_next.live.status[`ST_C] = alu.c;
               r_next.live.status[`ST_DIGIT] = alu.digit;
               r_next.live.status[`ST_Z] = alu.z;
            end
            `OP_MOV_WF, `OP_NOT_W, `OP_DEC_W, `OP_INC_W: begin
               r_next.live.w = alu.res;
               r_next.live.status = with_z(r_reg.live.status, alu.z);
            end
            `OP_RL_W, `OP_RR_W: begin
               r_next.live.w = alu.res;
               r_next.live.status[`ST_C] = alu.c;
            end
            `OP_SWAP_W: r_next.live.w = alu.res;
            `OP_DECSZ_W, `OP_INCSZ_W: begin
               r_next.live.w = alu.res;
               if (alu.z) begin
                  // skip by stepping over the next word, never fetching it
                  r_next.live.pc = r_reg.live.pc + 11'h002;
                  r_next.stall = `SKIP_EXTRA;
               end
            end
            `OP_RET_LIT: begin
               r_next.live.w = INSTR_I[7:0];
               r_next.live.pc = stack_top;
               pop = 1'b1;
               r_next.stall = `BRANCH_EXTRA;
            end
            `OP_CALL: begin
               r_next.live.pc = {r_reg.live.status[6:5], 1'b0, INSTR_I[7:0]};
               push = 1'b1;
               r_next.stall = `BRANCH_EXTRA;
            end
            `OP_JMP: begin
               r_next.live.pc = {r_reg.live.status[6:5], INSTR_I[8:0]};
               r_next.stall = `BRANCH_EXTRA;
            end
            `OP_LIT_W: r_next.live.w = INSTR_I[7:0];
            default: ;
         endcase
         // file write for move-to-file and test rewrite
         if ((INSTR_I ==? `OP_MOV_FW) || (INSTR_I ==? `OP_TEST)) begin
            // bit 9 tells the test rewrite from the move; both carry bit 5 set
            unique case (faddr)
               `ADDR_COUNTER: r_next.counter = INSTR_I[9] ? file_register_operand : r_reg.live.w;
               `ADDR_STATUS: r_next.live.status = INSTR_I[9] ? file_register_operand : r_reg.live.w;
               `ADDR_POINTER: r_next.live.pointer = INSTR_I[9] ? file_register_operand : r_reg.live.w;
               default: r_next.file[faddr] = INSTR_I[9] ? file_register_operand : r_reg.live.w;
            endcase
            if (INSTR_I[9]) begin
               r_next.live.status = with_z(r_next.live.status, file_register_operand == 8'h00);
            end
         end
      end
      // register bus: write takes address and data in one beat
      if (wr_go) begin
         r_next.bvalid = 1'b1;
         r_next.bresp = `RESP_DECERR;
         if (S_AXI_AWADDR == `REG_CTRL) begin
            r_next.bresp = `RESP_OKAY;
            if (S_AXI_WSTRB[0]) begin
               r_next.ctrl = S_AXI_WDATA[1:0];
            end
         end else if (S_AXI_AWADDR == `REG_OPTION) begin
            r_next.bresp = `RESP_OKAY;
            if (S_AXI_WSTRB[0]) begin
               r_next.option = S_AXI_WDATA[7:0];
            end
         end
      end else if (r_reg.bvalid && S_AXI_BREADY) begin
         r_next.bvalid = 1'b0;
      end
      // register bus: read
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         r_next.rvalid = 1'b1;
         r_next.rresp = `RESP_OKAY;
         unique case (S_AXI_ARADDR)
            `REG_CTRL: r_next.rdata = {30'h0, r_reg.ctrl};
            `REG_STATE: r_next.rdata = {5'h00, r_reg.live.pc, r_reg.live.status, r_reg.live.w};
            `REG_OPTION: r_next.rdata = {24'h000000, r_reg.option};
            default: begin
               r_next.rdata = 32'h00000000;
               r_next.rresp = `RESP_DECERR;
            end
         endcase
      end else if (r_reg.rvalid && S_AXI_RREADY) begin
         r_next.rvalid = 1'b0;
      end
   end
   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge CLOCK_I) begin
      if (SYS_RST_I) begin
         r_reg <= '0;
         r_reg.live.status <= `STATUS_RST;
         r_reg.option <= `OPTION_RST;
         r_reg.mode <= `MODE_RST;
         r_reg.ctrl <= `CTRL_RST;
      end else begin
         r_reg <= r_next;
      end
   end
   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // write side waits for both channels, so neither can be taken alone
   assign wr_go = S_AXI_AWVALID && S_AXI_WVALID && !r_reg.bvalid;
   assign S_AXI_AWREADY = wr_go;
   assign S_AXI_WREADY = wr_go;
   assign S_AXI_BVALID = r_reg.bvalid;
   assign S_AXI_BRESP = r_reg.bresp;
   assign S_AXI_ARREADY = !r_reg.rvalid;
   assign S_AXI_RVALID = r_reg.rvalid;
   assign S_AXI_RRESP = r_reg.rresp;
   assign S_AXI_RDATA = r_reg.rdata;
   assign FETCH_ADDR_O = r_reg.live.pc;
   assign W_O = r_reg.live.w;
   assign STATUS_O = r_reg.live.status;
   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (SYS_RST_I);
   a_movfw_keep_flags: assert property (
      take && (INSTR_I ==? `OP_MOV_FW) && faddr != `ADDR_STATUS |=> STATUS_O == $past(STATUS_O))
      else $error("move to file changed flags");
   a_literal_load: assert property (
      take && (INSTR_I ==? `OP_LIT_W) |=> W_O == $past(INSTR_I[7:0]) && STATUS_O == $past(STATUS_O))
      else $error("literal load wrong");
   a_mode_read_high: assert property (
      take && (INSTR_I ==? `OP_MODE_RD) |=> W_O[7:4] == 4'h0)
      else $error("mode read upper nibble not zero");
   a_not_move_z: assert property (
      take && (INSTR_I ==? `OP_NOT_W)
      |=> W_O == ~$past(file_register_operand) && STATUS_O[`ST_Z] == (W_O == 8'h00))
      else $error("complement move wrong");
   a_swap_nibbles: assert property (
      take && (INSTR_I ==? `OP_SWAP_W)
      |=> W_O == {$past(file_register_operand[3:0]), $past(file_register_operand[7:4])})
      else $error("nibble swap wrong");
   a_call_target_hold: assert property (
      take && (INSTR_I ==? `OP_CALL)
      |=> FETCH_ADDR_O == {$past(STATUS_O[6:5]), 1'b0, $past(INSTR_I[7:0])} ##0 (!INSTR_READY_O)[*2])
      else $error("call target or stall wrong");
   a_jump_target: assert property (
      take && (INSTR_I ==? `OP_JMP) |=> FETCH_ADDR_O == {$past(STATUS_O[6:5]), $past(INSTR_I[8:0])})
      else $error("jump target wrong");
   a_ret_pop_top: assert property (
      take && (INSTR_I ==? `OP_RET) |=> FETCH_ADDR_O == $past(stack_top) ##2 r_reg.stall == 2'h0)
      else $error("return target or timing wrong");
   a_skip_on_zero: assert property (
      take && ((INSTR_I ==? `OP_DECSZ_W) || (INSTR_I ==? `OP_INCSZ_W)) && alu.z
      |=> FETCH_ADDR_O == 11'($past(FETCH_ADDR_O) + 11'h002) && !INSTR_READY_O)
      else $error("skip did not step over word");
   // plain file cells above the pointer only: addresses 1, 3 and 4 alias live state
   a_file_write_acc: assert property (
      take && (INSTR_I ==? `OP_MOV_FW) && faddr > `ADDR_POINTER |=> r_reg.file[$past(faddr)] == $past(W_O))
      else $error("move to file stored wrong value");
   a_load_zero_flag: assert property (
      take && (INSTR_I ==? `OP_MOV_WF)
      |=> W_O == $past(file_register_operand) && STATUS_O[`ST_Z] == (W_O == 8'h00))
      else $error("move to accumulator wrong");
   c_call_taken: cover property (take && (INSTR_I ==? `OP_CALL));
   c_skip_taken: cover property (take && (INSTR_I ==? `OP_INCSZ_W) && alu.z);
   c_ret_int_add_taken: cover property (take && (INSTR_I ==? `OP_RET_INT_ADD));
   c_ret_lit_taken: cover property (take && (INSTR_I ==? `OP_RET_LIT));
endmodule // move_and_branch_decoder

// ### verif/prog_mem.sv
// program memory model feeding instruction words to the decoder
`timescale 1ns/100ps
module prog_mem (
   input wire logic clk_i,                      // system clock
   input wire logic rst_i,                      // synchronous reset
   input wire logic [10:0] addr_i,              // fetch address
   output logic [11:0] instr_o,                 // word at fetch address
   output logic valid_o                         // word valid
);
   logic [11:0] mem [0:2047];
   // unloaded locations read as no-operation words
   initial begin
      foreach (mem[i]) mem[i] = 12'h000;
   end
   // no word is offered before reset releases
   always_ff @(posedge clk_i) begin
      valid_o <= !rst_i;
   end
   assign instr_o = mem[addr_i];
endmodule // prog_mem

// ### verif/testbench.sv
// self-checking bench: program trace plus register bus accesses
`timescale 1ns/100ps
module testbench;
   logic clk = 0, rst = 1, ivalid, iready;
   logic [11:0] instr;
   logic [10:0] pc;
   logic [7:0] w, st;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [1:0] bresp, rresp, rsp;
   int n_fail = 0, n_tests = 0, k = 0;
   // fetch address and accumulator seen at each taken word
   logic [10:0] e_pc [16] = '{11'h000, 11'h001, 11'h002, 11'h003, 11'h004, 11'h005, 11'h006, 11'h007,
      11'h008, 11'h020, 11'h030, 11'h021, 11'h022, 11'h023, 11'h024, 11'h026};
   logic [7:0] e_w [16] = '{8'h00, 8'h5a, 8'h5a, 8'h00, 8'h5a, 8'ha5, 8'ha5, 8'h5b,
      8'h59, 8'h59, 8'h59, 8'h77, 8'hff, 8'hff, 8'hff, 8'h00};
   logic [11:0] prog [0:15] = '{12'hc5a, 12'h028, 12'hc00, 12'h208, 12'h248, 12'h388, 12'h288, 12'h0c8,
      12'ha20, 12'h930, 12'h877, 12'h2c9, 12'hcff, 12'h02a, 12'h3ca, 12'hc11};
   logic [10:0] at [0:15] = '{11'h000, 11'h001, 11'h002, 11'h003, 11'h004, 11'h005, 11'h006, 11'h007,
      11'h008, 11'h020, 11'h030, 11'h021, 11'h022, 11'h023, 11'h024, 11'h025};
   prog_mem PM (.clk_i(clk), .rst_i(rst), .addr_i(pc), .instr_o(instr), .valid_o(ivalid));
   move_and_branch_decoder DUT (.CLOCK_I(clk), .SYS_RST_I(rst), .INSTR_I(instr), .INSTR_VALID_I(ivalid),
      .INSTR_READY_O(iready), .FETCH_ADDR_O(pc), .SHADOW_SAVE_I(1'b0), .W_O(w), .STATUS_O(st),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready));
   // -------------------------------------------------------
   // shared tasks
   // -------------------------------------------------------
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // address and data offered together, both taken at one edge
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
      awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
      do @(posedge clk); while (!(awready && wready));
      awvalid <= 0; wvalid <= 0;
      while (!bvalid) @(posedge clk);
      rsp = bresp;
      bready <= 0;
      @(posedge clk);
   endtask
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] v);
      araddr <= a; arvalid <= 1; rready <= 1;
      do @(posedge clk); while (!arready);
      arvalid <= 0;
      while (!rvalid) @(posedge clk);
      v = rdata;
      rsp = rresp;
      rready <= 0;
      @(posedge clk);
   endtask
   task automatic complete_run;
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      forever #5 clk = ~clk;
   end
   // word trace: stalls after branches and the skipped word show up as gaps
   always @(posedge clk) begin
      if (!rst && ivalid === 1'b1 && iready === 1'b1 && k < 16) begin
         cmp("fetch address", e_pc[k], pc);
         cmp("accumulator", e_w[k], w);
         k++;
      end
   end
   // -------------------------------------------------------
   // main sequence
   // -------------------------------------------------------
   initial begin
      #1 foreach (prog[i]) PM.mem[at[i]] = prog[i];
      PM.mem[11'h026] = 12'ha26;
      repeat (16) @(posedge clk);
      rst <= 0;
      repeat (120) @(posedge clk);
      cmp("trace length", 16, k);
      $display("program trace done");
      axi_rd(4'h4, d);
      cmp("state word", {5'h00, 11'h026, 8'h18, 8'h00}, d);
      cmp("status", 32'h00000018, {24'h000000, st});
      axi_wr(4'h8, 32'h0000003c);
      cmp("write resp", 32'h0, {30'h0, rsp});
      axi_rd(4'h8, d);
      cmp("option", 32'h0000003c, d);
      axi_rd(4'hc, d);
      cmp("unmapped resp", 32'h3, {30'h0, rsp});
      cmp("unmapped data", 32'h0, d);
      $display("register bus done");
      complete_run();
   end
   initial begin
      #20000 n_fail++;
      complete_run();
   end
endmodule // testbench
